/* File: design/prd_ref_dividers.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
// Function
// RQ1 - All reference inputs disabled after reset.
// RQ2 - Differential receiver off unless selected, powered.
// RQ3 - Single-ended buffer off: PLL down, bit, differential.
// RQ4 - Switching only in dual single-ended mode.
// RQ5 - Manual change by register or select pin.
// RQ6 - Software ensures target clock or disables deglitch.
// RQ7 - Monitor pin high while primary invalid.
// RQ8 - Status pin may drive; secondary may be preferred.
// RQ9 - Deglitch blocks misaligned edges after a change.
// RQ10 - Automatic switching always reverts to preferred.
// RQ11 - Fourteen-bit reference divider over two registers.
// RQ12 - Reference settings zero and one divide by one.
// RQ13 - Reference divider reset: own, shared, sync.
// RQ14 - Feedback ratio is P times main plus swallow.
// RQ15 - Prescaler field: fixed 1-3 or dual modulus.
// RQ16 - Fixed-divide modes treat swallow as zero.
// RQ17 - Feedback divider covers one to its maximum.
// RQ18 - Software avoids 2/3 mode above its limit.
// RQ19 - Software keeps main count three or more.
// RQ20 - Software keeps swallow below main count.
// RQ21 - Main bypass: swallow zero, ratio equals P.
// RQ22 - Counter reset bits are not self-clearing.
// RQ23 - Configuration applies only after update write.
// RQ24 - Sync pin reset gated, disabled after reset.
// RQ25 - Counters held silent while reset bits set.
module prd_ref_dividers #(
  parameter int unsigned REF_LOSS_CYC = prd_pkg::REF_LOSS_CYC
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [prd_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        primary_reference,
  input  wire logic                        secondary_reference,
  input  wire logic                        vco_clk_in,
  input  wire logic                        ref_select_pin,
  input  wire logic                        sync_pin_n,
  output logic                             diff_rx_power_down,
  output logic                             primary_buf_power_down,
  output logic                             secondary_buf_power_down,
  output logic                             reference_monitor_pin,
  output logic                             status_pin,
  output logic                             secondary_selected,
  output logic                             r_div_pulse,
  output logic                             n_div_pulse
);

  localparam int unsigned LW = $clog2(REF_LOSS_CYC + 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_lvl;
  logic [4:0] pin_rise;

  prd_sync3 #(.WIDTH(5)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({sync_pin_n, ref_select_pin, vco_clk_in, secondary_reference, primary_reference}),
    .level    (pin_lvl),
    .rise     (pin_rise)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [11:0]       idx;
  logic [3:0]        slot;
  logic              wr_fire;
  logic              upd_fire;
  logic [7:0]        shadow_reg [prd_pkg::NSLOT];
  logic [7:0]        active_reg [prd_pkg::NACT];
  logic [7:0]        status_byte;
  prd_pkg::prd_cfg_s cfg;
  prd_pkg::prd_sw_e  sw_state;
  logic [1:0]        ref_valid;

  assign idx      = paddr[13:2];
  assign slot     = prd_pkg::slot_of(idx);
  assign wr_fire  = psel && penable && pwrite && pready;
  assign upd_fire = wr_fire && (idx == prd_pkg::IDX_UPDATE) && (pwdata[7:0] == prd_pkg::UPDATE_GO);
  assign status_byte = {4'h0, sw_state == prd_pkg::SW_WAIT, secondary_selected, ref_valid};

  // Zero wait states: the answer is prepared during the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= (slot == prd_pkg::SLOT_NONE) && (idx != prd_pkg::IDX_UPDATE)
                   && (idx != prd_pkg::IDX_STATUS);
        if (pwrite) begin
          prdata <= 32'h0000_0000;
        end else if (slot != prd_pkg::SLOT_NONE) begin
          prdata <= {24'h00_0000, shadow_reg[slot]};
        end else if (idx == prd_pkg::IDX_STATUS) begin
          prdata <= {24'h00_0000, status_byte};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < prd_pkg::NSLOT; i++) begin
        shadow_reg[i] <= prd_pkg::RST_VAL;  // RQ1
      end
    end else if (wr_fire && (slot != prd_pkg::SLOT_NONE)) begin
      shadow_reg[slot] <= pwdata[7:0];
    end
  end

  // Staged values go live together so the loop never sees a half-written ratio.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < prd_pkg::NACT; i++) begin
        active_reg[i] <= prd_pkg::RST_VAL;
      end
    end else if (upd_fire) begin  // RQ23
      for (int i = 0; i < prd_pkg::NACT; i++) begin
        active_reg[i] <= shadow_reg[i];
      end
    end
  end

  assign cfg.r_div     = {active_reg[prd_pkg::SLOT_RHI][5:0], active_reg[prd_pkg::SLOT_RLO]};  // RQ11
  assign cfg.swallow   = active_reg[prd_pkg::SLOT_SWALLOW][5:0];
  assign cfg.main_cnt  = {active_reg[prd_pkg::SLOT_MHI][4:0], active_reg[prd_pkg::SLOT_MLO]};
  assign cfg.presc     = prd_pkg::prd_presc_e'(active_reg[prd_pkg::SLOT_PRESC][2:0]);
  assign cfg.sync_ctrl = active_reg[prd_pkg::SLOT_SYNC][7:6];
  assign cfg.mon_sel   = active_reg[prd_pkg::SLOT_MON];
  assign cfg.ref_ctrl  = active_reg[prd_pkg::SLOT_REF];
  assign cfg.pll_pd    = active_reg[prd_pkg::SLOT_PLL][1:0] != 2'b00;

  // ----------------------------------------------------------------
  // Input power control
  // ----------------------------------------------------------------
  logic diff_mode;
  logic pri_en;
  logic sec_en;
  logic dual_mode;
  logic sec_only;

  assign diff_mode = cfg.ref_ctrl[prd_pkg::REF_DIFF];
  assign pri_en    = cfg.ref_ctrl[prd_pkg::REF_PRI_EN];
  assign sec_en    = cfg.ref_ctrl[prd_pkg::REF_SEC_EN];
  assign dual_mode = !diff_mode && pri_en && sec_en;
  assign sec_only  = !diff_mode && !pri_en && sec_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_rx_power_down       <= 1'b1;
      primary_buf_power_down   <= 1'b1;
      secondary_buf_power_down <= 1'b1;
    end else begin
      diff_rx_power_down       <= cfg.pll_pd || !diff_mode;            // RQ2
      primary_buf_power_down   <= cfg.pll_pd || !pri_en || diff_mode;  // RQ3
      secondary_buf_power_down <= cfg.pll_pd || !sec_en || diff_mode;  // RQ3
    end
  end

  // ----------------------------------------------------------------
  // Reference monitors and monitor pins
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_mon
    logic [LW-1:0] loss_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        loss_cnt <= LW'(REF_LOSS_CYC);
      end else if (pin_rise[i]) begin
        loss_cnt <= '0;
      end else if (loss_cnt < LW'(REF_LOSS_CYC)) begin
        loss_cnt <= loss_cnt + 1'b1;
      end
    end
    assign ref_valid[i] = loss_cnt < LW'(REF_LOSS_CYC);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_monitor_pin <= 1'b0;
      status_pin            <= 1'b0;
    end else begin
      reference_monitor_pin <= ((cfg.mon_sel[3:0] == prd_pkg::MON_PRI_BAD) && !ref_valid[0])  // RQ7
                             || ((cfg.mon_sel[3:0] == prd_pkg::MON_SEC_BAD) && !ref_valid[1]);
      status_pin            <= ((cfg.mon_sel[7:4] == prd_pkg::MON_PRI_BAD) && !ref_valid[0])  // RQ8
                             || ((cfg.mon_sel[7:4] == prd_pkg::MON_SEC_BAD) && !ref_valid[1]);
    end
  end

  // ----------------------------------------------------------------
  // Reference selection and deglitch
  // ----------------------------------------------------------------
  logic target_sec;
  logic auto_cmd;
  logic sel_rise;
  logic ref_usable;
  logic r_edge;
  logic restart;

  assign auto_cmd = reference_monitor_pin || status_pin;  // RQ8

  always_comb begin
    if (!dual_mode) begin
      target_sec = sec_only;  // RQ4
    end else if (cfg.ref_ctrl[prd_pkg::REF_AUTO]) begin
      // Revertive only: the choice follows the monitor and status pins with no memory.
      target_sec = cfg.ref_ctrl[prd_pkg::REF_PREF_SEC] ^ auto_cmd;  // RQ10
    end else if (cfg.ref_ctrl[prd_pkg::REF_PIN_SEL]) begin
      target_sec = pin_lvl[3];  // RQ5
    end else begin
      target_sec = cfg.ref_ctrl[prd_pkg::REF_MAN_SEC];  // RQ5
    end
  end

  assign sel_rise   = secondary_selected ? pin_rise[1] : pin_rise[0];
  assign ref_usable = !cfg.pll_pd && (diff_mode || (secondary_selected ? sec_en : pri_en));  // RQ1
  assign r_edge     = sel_rise && ref_usable && (sw_state == prd_pkg::SW_TRACK);  // RQ9
  assign restart    = (sw_state == prd_pkg::SW_WAIT) && sel_rise;

  // A dead target keeps the gate shut for good unless deglitch is off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_selected <= 1'b0;
      sw_state           <= prd_pkg::SW_TRACK;
    end else if (target_sec != secondary_selected) begin
      secondary_selected <= target_sec;
      sw_state <= cfg.ref_ctrl[prd_pkg::REF_DGL_DIS] ? prd_pkg::SW_TRACK : prd_pkg::SW_WAIT;  // RQ9 RQ6
    end else begin
      case (sw_state)
        prd_pkg::SW_WAIT:  sw_state <= restart ? prd_pkg::SW_TRACK : prd_pkg::SW_WAIT;
        prd_pkg::SW_TRACK: sw_state <= prd_pkg::SW_TRACK;
        default:           sw_state <= prd_pkg::SW_TRACK;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reference divider
  // ----------------------------------------------------------------
  logic [13:0] r_cnt;
  logic [13:0] r_term;
  logic        sync_rst;
  logic        r_hold;
  logic        n_hold;
  logic [7:0]  drst;

  assign drst     = shadow_reg[prd_pkg::SLOT_DRST];  // RQ22
  assign sync_rst = (cfg.sync_ctrl != 2'b00) && !pin_lvl[4];  // RQ24
  assign r_hold   = drst[prd_pkg::DRST_R] || drst[prd_pkg::DRST_SHARED] || sync_rst;  // RQ13
  assign n_hold   = drst[prd_pkg::DRST_AB] || drst[prd_pkg::DRST_SHARED] || sync_rst;  // RQ22
  assign r_term   = (cfg.r_div == 14'h0000) ? 14'h0000 : cfg.r_div - 14'h0001;  // RQ12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_cnt       <= 14'h0000;
      r_div_pulse <= 1'b0;
    end else if (r_hold || restart) begin  // RQ25
      r_cnt       <= 14'h0000;
      r_div_pulse <= 1'b0;
    end else if (r_edge) begin
      r_cnt       <= (r_cnt >= r_term) ? 14'h0000 : r_cnt + 14'h0001;
      r_div_pulse <= r_cnt >= r_term;
    end else begin
      r_div_pulse <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Feedback divider
  // ----------------------------------------------------------------
  logic [5:0]  p_val;
  logic        fixed_mode;
  logic [5:0]  a_eff;
  logic [18:0] n_total;
  logic [18:0] n_term;
  logic [18:0] n_cnt;

  always_comb begin
    case (cfg.presc)  // RQ15
      prd_pkg::PRESC_FD1:  p_val = 6'h01;
      prd_pkg::PRESC_FD2:  p_val = 6'h02;
      prd_pkg::PRESC_FD3:  p_val = 6'h03;
      prd_pkg::PRESC_DM2:  p_val = 6'h02;
      prd_pkg::PRESC_DM4:  p_val = 6'h04;
      prd_pkg::PRESC_DM8:  p_val = 6'h08;
      prd_pkg::PRESC_DM16: p_val = 6'h10;
      prd_pkg::PRESC_DM32: p_val = 6'h20;
      default:             p_val = 6'h01;
    endcase
  end

  // The ratio is counted whole; it equals P*B+A but is not swallowed edge for edge.
  assign fixed_mode = cfg.presc inside {prd_pkg::PRESC_FD1, prd_pkg::PRESC_FD2, prd_pkg::PRESC_FD3};
  assign a_eff      = fixed_mode ? 6'h00 : cfg.swallow;  // RQ16
  assign n_total    = ({13'h0000, p_val} * {6'h00, cfg.main_cnt}) + {13'h0000, a_eff};  // RQ14 RQ17 RQ21
  assign n_term     = (n_total == 19'h00000) ? 19'h00000 : n_total - 19'h00001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_cnt       <= 19'h00000;
      n_div_pulse <= 1'b0;
    end else if (n_hold) begin  // RQ25
      n_cnt       <= 19'h00000;
      n_div_pulse <= 1'b0;
    end else if (pin_rise[2] && !cfg.pll_pd) begin
      n_cnt       <= (n_cnt >= n_term) ? 19'h00000 : n_cnt + 19'h00001;
      n_div_pulse <= n_cnt >= n_term;
    end else begin
      n_div_pulse <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_diff_pd;
    @(posedge pclk) disable iff (!presetn)
    (cfg.pll_pd || !diff_mode) |=> diff_rx_power_down;
  endproperty
  a_diff_pd: assert property (p_diff_pd) else $error("differential receiver left powered"); // RQ2

  property p_se_pd;
    @(posedge pclk) disable iff (!presetn)
    (diff_mode || cfg.pll_pd) |=> (primary_buf_power_down && secondary_buf_power_down);
  endproperty
  a_se_pd: assert property (p_se_pd) else $error("single-ended buffer left powered"); // RQ3

  property p_no_switch;
    @(posedge pclk) disable iff (!presetn)
    (!dual_mode && !sec_only) |=> !secondary_selected;
  endproperty
  a_no_switch: assert property (p_no_switch) else $error("secondary chosen outside dual mode"); // RQ4

  property p_monitor;
    @(posedge pclk) disable iff (!presetn)
    (cfg.mon_sel[3:0] == prd_pkg::MON_PRI_BAD) && !ref_valid[0] |=> reference_monitor_pin;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor pin low while primary invalid"); // RQ7

  sequence s_switch_dgl;
    (target_sec != secondary_selected) && !cfg.ref_ctrl[prd_pkg::REF_DGL_DIS];
  endsequence
  sequence s_gate_shut;
    (sw_state == prd_pkg::SW_WAIT) && !r_edge;
  endsequence
  property p_deglitch;
    @(posedge pclk) disable iff (!presetn)
    s_switch_dgl |=> s_gate_shut;
  endproperty
  a_deglitch: assert property (p_deglitch) else $error("edge passed during deglitch wait"); // RQ9

  property p_rdiv_one;
    @(posedge pclk) disable iff (!presetn)
    (r_edge && (cfg.r_div <= 14'h0001) && !r_hold) |=> r_div_pulse;
  endproperty
  a_rdiv_one: assert property (p_rdiv_one) else $error("setting zero or one did not divide by one"); // RQ12

  property p_hold_quiet;
    @(posedge pclk) disable iff (!presetn)
    (r_hold && n_hold)[*2] |-> (!r_div_pulse && !n_div_pulse && r_cnt == 14'h0000);
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("divider active while reset held"); // RQ25

  property p_update_only;
    @(posedge pclk) disable iff (!presetn)
    !upd_fire |=> $stable(cfg);
  endproperty
  a_update_only: assert property (p_update_only) else $error("configuration changed without update"); // RQ23

  property p_fixed_ratio;
    @(posedge pclk) disable iff (!presetn)
    fixed_mode |-> (n_total == ({13'h0000, p_val} * {6'h00, cfg.main_cnt}));
  endproperty
  a_fixed_ratio: assert property (p_fixed_ratio) else $error("swallow count used in fixed mode"); // RQ16

  property p_sync_off;
    @(posedge pclk) disable iff (!presetn)
    (cfg.sync_ctrl == 2'b00) |-> !sync_rst;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync pin reset while disabled"); // RQ24

endmodule

/* File: design/prd_pkg.sv */
package prd_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned REF_LOSS_NS   = 100;
  // A longest time rounds down to whole cycles.
  localparam int unsigned REF_LOSS_CYC  = (REF_LOSS_NS * 1000) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 14;
  localparam logic [11:0] IDX_PLL_CTRL  = 12'h010;
  localparam logic [11:0] IDX_RDIV_LO   = 12'h011;
  localparam logic [11:0] IDX_RDIV_HI   = 12'h012;
  localparam logic [11:0] IDX_SWALLOW   = 12'h013;
  localparam logic [11:0] IDX_MAIN_LO   = 12'h014;
  localparam logic [11:0] IDX_MAIN_HI   = 12'h015;
  localparam logic [11:0] IDX_PRESC     = 12'h016;
  localparam logic [11:0] IDX_SYNC_CTRL = 12'h019;
  localparam logic [11:0] IDX_MON_SEL   = 12'h01b;
  localparam logic [11:0] IDX_REF_CTRL  = 12'h01c;
  localparam logic [11:0] IDX_DIV_RST   = 12'h01e;
  localparam logic [11:0] IDX_STATUS    = 12'h01f;
  localparam logic [11:0] IDX_UPDATE    = 12'h232;

  localparam logic [7:0]  RST_VAL       = 8'h00;
  localparam logic [7:0]  UPDATE_GO     = 8'h01;

  // ----------------------------------------------------------------
  // Storage slots
  // ----------------------------------------------------------------
  localparam int unsigned NSLOT         = 11;
  localparam int unsigned NACT          = 10;
  localparam logic [3:0]  SLOT_PLL      = 4'h0;
  localparam logic [3:0]  SLOT_RLO      = 4'h1;
  localparam logic [3:0]  SLOT_RHI      = 4'h2;
  localparam logic [3:0]  SLOT_SWALLOW  = 4'h3;
  localparam logic [3:0]  SLOT_MLO      = 4'h4;
  localparam logic [3:0]  SLOT_MHI      = 4'h5;
  localparam logic [3:0]  SLOT_PRESC    = 4'h6;
  localparam logic [3:0]  SLOT_SYNC     = 4'h7;
  localparam logic [3:0]  SLOT_MON      = 4'h8;
  localparam logic [3:0]  SLOT_REF      = 4'h9;
  localparam logic [3:0]  SLOT_DRST     = 4'ha;
  localparam logic [3:0]  SLOT_NONE     = 4'hf;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned REF_DIFF      = 0;
  localparam int unsigned REF_PRI_EN    = 1;
  localparam int unsigned REF_SEC_EN    = 2;
  localparam int unsigned REF_PIN_SEL   = 3;
  localparam int unsigned REF_PREF_SEC  = 4;
  localparam int unsigned REF_AUTO      = 5;
  localparam int unsigned REF_MAN_SEC   = 6;
  localparam int unsigned REF_DGL_DIS   = 7;
  localparam int unsigned DRST_R        = 0;
  localparam int unsigned DRST_AB       = 1;
  localparam int unsigned DRST_SHARED   = 2;
  localparam logic [3:0]  MON_PRI_BAD   = 4'h7;
  localparam logic [3:0]  MON_SEC_BAD   = 4'h8;

  typedef enum logic [2:0] {
    PRESC_FD1  = 3'b000,
    PRESC_FD2  = 3'b001,
    PRESC_FD3  = 3'b010,
    PRESC_DM2  = 3'b011,
    PRESC_DM4  = 3'b100,
    PRESC_DM8  = 3'b101,
    PRESC_DM16 = 3'b110,
    PRESC_DM32 = 3'b111
  } prd_presc_e;

  typedef enum logic [0:0] {
    SW_TRACK = 1'b0,
    SW_WAIT  = 1'b1
  } prd_sw_e;

  typedef struct packed {
    logic [13:0] r_div;
    logic [5:0]  swallow;
    logic [12:0] main_cnt;
    prd_presc_e  presc;
    logic [1:0]  sync_ctrl;
    logic [7:0]  mon_sel;
    logic [7:0]  ref_ctrl;
    logic        pll_pd;
  } prd_cfg_s;

  function automatic logic [3:0] slot_of(input logic [11:0] idx);
    case (idx)
      IDX_PLL_CTRL:  slot_of = SLOT_PLL;
      IDX_RDIV_LO:   slot_of = SLOT_RLO;
      IDX_RDIV_HI:   slot_of = SLOT_RHI;
      IDX_SWALLOW:   slot_of = SLOT_SWALLOW;
      IDX_MAIN_LO:   slot_of = SLOT_MLO;
      IDX_MAIN_HI:   slot_of = SLOT_MHI;
      IDX_PRESC:     slot_of = SLOT_PRESC;
      IDX_SYNC_CTRL: slot_of = SLOT_SYNC;
      IDX_MON_SEL:   slot_of = SLOT_MON;
      IDX_REF_CTRL:  slot_of = SLOT_REF;
      IDX_DIV_RST:   slot_of = SLOT_DRST;
      default:       slot_of = SLOT_NONE;
    endcase
  endfunction

endpackage

/* File: design/prd_sync3.sv */
`timescale 1ns/1ps
module prd_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  // ----------------------------------------------------------------
  // Per-bit three-stage synchroniser
  // ----------------------------------------------------------------
  // The first stage feeds only the second; a change counts once the
  // second and third stages agree, which filters one-cycle runts.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_reg   <= 1'b0;
        s2_reg   <= 1'b0;
        s3_reg   <= 1'b0;
        level[i] <= 1'b0;
        rise[i]  <= 1'b0;
      end else begin
        s1_reg <= async_in[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) begin
          level[i] <= s3_reg;
        end
        rise[i] <= (s2_reg == s3_reg) && s3_reg && !level[i];
      end
    end
  end

endmodule

/* File: bench/prd_clk_src.sv */
`timescale 1ns/1ps
module prd_clk_src (
  input  wire logic       pclk,
  input  wire logic [2:0] run,
  output logic      [2:0] clk_o
);
  logic [1:0] cnt = 2'h0;
  // A stopped source rests low, so a lost reference is never mistaken for a live one.
  always_ff @(posedge pclk) begin
    cnt <= cnt + 2'h1;
    clk_o <= run & {3{cnt[1]}};
  end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        sel_pin = 1'b0;
  logic        sync_n = 1'b1;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rdv;
  logic        pready;
  logic        pslverr;
  logic        slv;
  logic [2:0]  run = 3'h0;
  logic [2:0]  clks;
  logic [2:0]  pd;
  logic [2:0]  mon;
  logic [1:0]  pl;
  int          errors = 0;
  int          checks = 0;
  int          g;
  int          a;
  int          b;
  int          r;

  prd_clk_src src (.pclk(pclk), .run(run), .clk_o(clks));
  prd_ref_dividers #(.REF_LOSS_CYC(8)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_reference(clks[0]), .secondary_reference(clks[1]), .vco_clk_in(clks[2]),
    .ref_select_pin(sel_pin), .sync_pin_n(sync_n), .diff_rx_power_down(pd[2]),
    .primary_buf_power_down(pd[1]), .secondary_buf_power_down(pd[0]),
    .reference_monitor_pin(mon[1]), .status_pin(mon[2]), .secondary_selected(mon[0]),
    .r_div_pulse(pl[0]), .n_div_pulse(pl[1]));

  initial forever #2 pclk = ~pclk;

  // ------------------------------------------------------------
  // Bus, measurement and check tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic upd;
    apb(1'b1, prd_pkg::IDX_UPDATE, prd_pkg::UPDATE_GO);
    repeat (3) @(negedge pclk);
  endtask

  // The first gap after a change may be short, so only the second one is measured.
  task automatic gap(input int s, output int c);
    repeat (2) begin
      c = 1;
      @(negedge pclk);
      while (pl[s] !== 1'b1 && c < 3000) begin
        @(negedge pclk);
        c++;
      end
    end
  endtask

  task automatic sw(input logic [7:0] c, input logic p, input logic [2:0] e);
    @(posedge pclk);
    sel_pin <= p;
    apb(1'b1, prd_pkg::IDX_REF_CTRL, c);
    upd;
    repeat (10) @(negedge pclk);
    chk("select", mon, e);
  endtask

  function automatic int nexp(input int m, input int b, input int a);
    int p;
    p = (m < 3) ? m + 1 : 2 << (m - 3);
    return (m < 3) ? p * b : p * b + a;
  endfunction

  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    test_done;
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'hd60300ec));
    chk("pd_reset", pd, 3'b111);
    apb(1'b0, prd_pkg::IDX_REF_CTRL, 8'h00);
    chk("ref_ctrl", rdv, 32'h0);
    apb(1'b0, 12'h3ff, 8'h00);
    chk("unmapped", slv, 1'b1);
    apb(1'b1, prd_pkg::IDX_REF_CTRL, 8'h01);
    upd;
    chk("pd_diff", pd, 3'b011);
    apb(1'b1, prd_pkg::IDX_REF_CTRL, 8'h02);
    chk("pd_staged", pd, 3'b011);
    upd;
    chk("pd_primary", pd, 3'b101);
    $display("test power done");
    run <= 3'b111;
    for (int k = 0; k < 4; k++) begin
      r = (k < 2) ? k : 2 + $urandom % 7;
      apb(1'b1, prd_pkg::IDX_RDIV_LO, r[7:0]);
      upd;
      gap(0, g);
      chk("r_period", g, (r < 2 ? 1 : r) * 4);
    end
    // The slow VCO keeps every prescaler mode inside its input limit.
    for (int m = 0; m < 8; m++) begin
      b = (m == 0) ? 1 : 3 + $urandom % 6;
      a = (b == 1) ? 0 : $urandom % b;
      apb(1'b1, prd_pkg::IDX_SWALLOW, a[7:0]);
      apb(1'b1, prd_pkg::IDX_MAIN_LO, b[7:0]);
      apb(1'b1, prd_pkg::IDX_PRESC, m[7:0]);
      upd;
      gap(1, g);
      chk("n_period", g, nexp(m, b, a) * 4);
    end
    $display("test dividers done");
    apb(1'b1, prd_pkg::IDX_DIV_RST, 8'h04);
    gap(0, g);
    chk("r_held", g, 3000);
    gap(1, g);
    chk("n_held", g, 3000);
    apb(1'b0, prd_pkg::IDX_DIV_RST, 8'h00);
    chk("drst_kept", rdv, 32'h4);
    @(posedge pclk);
    sync_n <= 1'b0;
    apb(1'b1, prd_pkg::IDX_DIV_RST, 8'h01);
    gap(1, g);
    chk("n_free", g, nexp(7, b, a) * 4);
    gap(0, g);
    chk("r_own", g, 3000);
    apb(1'b1, prd_pkg::IDX_DIV_RST, 8'h00);
    apb(1'b1, prd_pkg::IDX_SYNC_CTRL, 8'h40);
    upd;
    gap(0, g);
    chk("r_sync", g, 3000);
    @(posedge pclk);
    sync_n <= 1'b1;
    $display("test reset done");
    apb(1'b1, prd_pkg::IDX_MON_SEL, 8'h80);
    apb(1'b1, prd_pkg::IDX_REF_CTRL, 8'h36);
    upd;
    run <= 3'b101;
    repeat (40) @(negedge pclk);
    chk("stat_lost", mon, 3'b100);
    run <= 3'b111;
    repeat (40) @(negedge pclk);
    chk("stat_back", mon, 3'b001);
    apb(1'b1, prd_pkg::IDX_MON_SEL, 8'hf7);
    apb(1'b1, prd_pkg::IDX_REF_CTRL, 8'h26);
    upd;
    run <= 3'b110;
    repeat (40) @(negedge pclk);
    chk("auto_lost", mon, 3'b011);
    run <= 3'b111;
    repeat (40) @(negedge pclk);
    chk("auto_back", mon, 3'b000);
    sw(8'h0e, 1'b1, 3'b001);
    sw(8'h46, 1'b0, 3'b001);
    sw(8'h4f, 1'b1, 3'b000);
    $display("test switch done");
    test_done;
  end
endmodule
